// ==== common/sleep_ctrl_pkg.sv ====
package sleep_ctrl_pkg;

    // mode selection codes
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_RSVD_1 = 3'h1;
    localparam logic [2:0] MODE_DEEP = 3'h2;
    localparam logic [2:0] MODE_COUNTER_KEPT = 3'h3;
    localparam logic [2:0] MODE_RSVD_4 = 3'h4;
    localparam logic [2:0] MODE_RSVD_5 = 3'h5;
    localparam logic [2:0] MODE_OSC_KEPT = 3'h6;
    localparam logic [2:0] MODE_OSC_COUNTER_KEPT = 3'h7;

    // halt after wake-up, in cpu clock cycles
    localparam int HALT_CYCLES = 4;
    localparam logic [2:0] HALT_LAST = 3'(HALT_CYCLES - 1);
    localparam logic [2:0] HALT_FIRST = 3'h0;

    // clock figures
    localparam int CLK_PERIOD_NS = 8;

    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_SLEEP = 2'b01,
        ST_OSC_WAIT = 2'b10,
        ST_HALT = 2'b11
    } state_type;

endpackage

// ==== rtl/pin_sync.sv ====
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // asynchronous and filtered levels
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] late_q;

    initial begin
        if (WIDTH < 1) begin
            $error("pin_sync width must be at least one");
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
            late_q <= '0;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            late_q <= sync_q;
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            level_o <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (sync_q[i] == late_q[i]) begin
                    level_o[i] <= late_q[i];
                end
            end
        end
    end
endmodule

// ==== rtl/sleep_mode_controller.sv ====
`timescale 1ns/100ps
module sleep_mode_controller #(
    parameter int PERIPH_COUNT = 8
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // processor side
    input wire logic sleep_exec_i,
    input wire logic sleep_entry_allow_i,
    input wire logic [2:0] sleep_mode_select_i,
    input wire logic nvm_busy_i,
    // peripheral clock stop bits from software
    input wire logic [PERIPH_COUNT-1:0] periph_stop_i,
    // same-clock wake sources
    input wire logic any_irq_i,
    input wire logic rtc_irq_i,
    input wire logic rtc_run_i,
    // asynchronous wake sources and oscillator status
    input wire logic usb_resume_i,
    input wire logic port_async_irq_i,
    input wire logic twi_addr_match_i,
    input wire logic sys_osc_ready_i,
    // clock gating
    output logic cpu_clk_en_o,
    output logic nvm_clk_en_o,
    output logic [PERIPH_COUNT-1:0] periph_clk_en_o,
    output logic rtc_clk_en_o,
    output logic sys_osc_en_o,
    output logic rtc_osc_en_o,
    // processor control and status
    output logic cpu_halt_o,
    output logic sleeping_o,
    output logic resume_isr_o,
    output logic reset_vector_o,
    output logic [2:0] mode_o
);
    sleep_ctrl_pkg::state_type state_q, state_d;
    logic [2:0] mode_q;
    logic [2:0] mode_eff;
    logic [2:0] halt_cnt_q;
    logic [3:0] async_lvl;
    logic usb_s, port_s, twi_s, osc_rdy_s;
    logic mode_ok, sys_kept, rtc_kept, wake_now;
    logic per_dom_d, rtc_dom_d, sys_osc_d, rtc_osc_d;

    initial begin
        if (PERIPH_COUNT < 1) begin
            $error("peripheral count must be at least one");
        end
    end

    pin_sync #(.WIDTH(4)) u_pin_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .pin_i({sys_osc_ready_i, twi_addr_match_i, port_async_irq_i, usb_resume_i}),
        .level_o(async_lvl)
    );
    assign usb_s = async_lvl[0];
    assign port_s = async_lvl[1];
    assign twi_s = async_lvl[2];
    assign osc_rdy_s = async_lvl[3];

    // decode of the requested code
    always_comb begin
        case (sleep_mode_select_i)
            sleep_ctrl_pkg::MODE_IDLE, sleep_ctrl_pkg::MODE_DEEP,
            sleep_ctrl_pkg::MODE_COUNTER_KEPT, sleep_ctrl_pkg::MODE_OSC_KEPT,
            sleep_ctrl_pkg::MODE_OSC_COUNTER_KEPT: mode_ok = 1'b1;
            default: mode_ok = 1'b0;
        endcase
    end

    // mode in force for the next state: the requested code on the entry edge
    always_comb begin
        mode_eff = (state_q == sleep_ctrl_pkg::ST_ACTIVE) ? sleep_mode_select_i : mode_q;
    end

    // per-mode resources of the mode being entered or held
    always_comb begin
        sys_kept = 1'b0;
        rtc_kept = 1'b0;
        case (mode_eff)
            sleep_ctrl_pkg::MODE_IDLE: begin
                sys_kept = 1'b1;
                rtc_kept = 1'b1;
            end
            sleep_ctrl_pkg::MODE_COUNTER_KEPT: rtc_kept = 1'b1;
            sleep_ctrl_pkg::MODE_OSC_KEPT: sys_kept = 1'b1;
            sleep_ctrl_pkg::MODE_OSC_COUNTER_KEPT: begin
                sys_kept = 1'b1;
                rtc_kept = 1'b1;
            end
            default: begin
                sys_kept = 1'b0;
                rtc_kept = 1'b0;
            end
        endcase
    end

    // wake sources allowed in the latched mode
    always_comb begin
        wake_now = usb_s | port_s | twi_s;
        if (mode_q == sleep_ctrl_pkg::MODE_IDLE) begin
            wake_now = wake_now | any_irq_i | rtc_irq_i;
        end else if (rtc_kept) begin
            wake_now = wake_now | (rtc_irq_i & rtc_run_i);
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            sleep_ctrl_pkg::ST_ACTIVE: begin
                if (sleep_exec_i && sleep_entry_allow_i && mode_ok) begin
                    state_d = sleep_ctrl_pkg::ST_SLEEP;
                end
            end
            sleep_ctrl_pkg::ST_SLEEP: begin
                if (wake_now) begin
                    state_d = sys_kept ? sleep_ctrl_pkg::ST_HALT : sleep_ctrl_pkg::ST_OSC_WAIT;
                end
            end
            sleep_ctrl_pkg::ST_OSC_WAIT: begin
                if (osc_rdy_s) begin
                    state_d = sleep_ctrl_pkg::ST_HALT;
                end
            end
            sleep_ctrl_pkg::ST_HALT: begin
                if (halt_cnt_q == sleep_ctrl_pkg::HALT_LAST) begin
                    state_d = sleep_ctrl_pkg::ST_ACTIVE;
                end
            end
            default: state_d = sleep_ctrl_pkg::ST_ACTIVE;
        endcase
    end

    // domains wanted in the next state
    always_comb begin
        per_dom_d = 1'b1;
        rtc_dom_d = 1'b1;
        sys_osc_d = 1'b1;
        rtc_osc_d = 1'b1;
        if (state_d == sleep_ctrl_pkg::ST_SLEEP || state_d == sleep_ctrl_pkg::ST_OSC_WAIT) begin
            per_dom_d = (mode_eff == sleep_ctrl_pkg::MODE_IDLE);
            rtc_dom_d = rtc_kept;
            rtc_osc_d = rtc_kept;
            sys_osc_d = sys_kept || state_d == sleep_ctrl_pkg::ST_OSC_WAIT;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_q <= sleep_ctrl_pkg::ST_ACTIVE;
        end else begin
            state_q <= state_d;
        end
    end

    // mode latched at entry, held through sleep
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            mode_q <= sleep_ctrl_pkg::MODE_IDLE;
        end else if (state_q == sleep_ctrl_pkg::ST_ACTIVE && state_d == sleep_ctrl_pkg::ST_SLEEP) begin
            mode_q <= sleep_mode_select_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            halt_cnt_q <= sleep_ctrl_pkg::HALT_FIRST;
        end else if (state_q == sleep_ctrl_pkg::ST_HALT) begin
            halt_cnt_q <= halt_cnt_q + 3'h1;
        end else begin
            halt_cnt_q <= sleep_ctrl_pkg::HALT_FIRST;
        end
    end

    // clock gates; gating only, nothing is cleared on entry
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cpu_clk_en_o <= 1'b1;
            nvm_clk_en_o <= 1'b1;
            periph_clk_en_o <= '1;
            rtc_clk_en_o <= 1'b1;
            sys_osc_en_o <= 1'b1;
            rtc_osc_en_o <= 1'b1;
        end else begin
            cpu_clk_en_o <= (state_d == sleep_ctrl_pkg::ST_ACTIVE || state_d == sleep_ctrl_pkg::ST_HALT);
            nvm_clk_en_o <= (state_d == sleep_ctrl_pkg::ST_ACTIVE) || nvm_busy_i;
            periph_clk_en_o <= {PERIPH_COUNT{per_dom_d}} & ~periph_stop_i;
            rtc_clk_en_o <= rtc_dom_d;
            sys_osc_en_o <= sys_osc_d;
            rtc_osc_en_o <= rtc_osc_d;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cpu_halt_o <= 1'b0;
            sleeping_o <= 1'b0;
            resume_isr_o <= 1'b0;
            reset_vector_o <= 1'b1;
            mode_o <= sleep_ctrl_pkg::MODE_IDLE;
        end else begin
            cpu_halt_o <= (state_d != sleep_ctrl_pkg::ST_ACTIVE);
            sleeping_o <= (state_d == sleep_ctrl_pkg::ST_SLEEP || state_d == sleep_ctrl_pkg::ST_OSC_WAIT);
            resume_isr_o <= (state_q == sleep_ctrl_pkg::ST_HALT && state_d == sleep_ctrl_pkg::ST_ACTIVE);
            reset_vector_o <= 1'b0;
            mode_o <= (state_q == sleep_ctrl_pkg::ST_ACTIVE && state_d == sleep_ctrl_pkg::ST_SLEEP) ? sleep_mode_select_i : mode_q;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    a_refused_entry: assert property (state_q == sleep_ctrl_pkg::ST_ACTIVE && sleep_exec_i && !(sleep_entry_allow_i && mode_ok) |=> !sleeping_o && cpu_clk_en_o) else $error("sleep entered without allow or with reserved code");
    a_entry_taken: assert property (state_q == sleep_ctrl_pkg::ST_ACTIVE && sleep_exec_i && sleep_entry_allow_i && mode_ok |=> sleeping_o && !cpu_clk_en_o && cpu_halt_o && mode_o == $past(sleep_mode_select_i)) else $error("valid sleep request not taken");
    a_halt_on_entry: assert property ($rose(cpu_halt_o) |-> sleeping_o && !cpu_clk_en_o) else $error("halt raised outside sleep entry");
    a_halt_after_sleep: assert property ($fell(sleeping_o) |-> cpu_halt_o [*4] ##1 !cpu_halt_o) else $error("halt after wake not four cycles");
    a_resume_pulse: assert property ($fell(cpu_halt_o) |-> resume_isr_o ##1 !resume_isr_o) else $error("resume not signalled at end of halt");
    a_deep_off: assert property (sleeping_o && mode_q == sleep_ctrl_pkg::MODE_DEEP |-> !rtc_clk_en_o && !rtc_osc_en_o && periph_clk_en_o == '0) else $error("clock running in deep halt");
    a_idle_on: assert property (sleeping_o && mode_q == sleep_ctrl_pkg::MODE_IDLE |-> rtc_clk_en_o && sys_osc_en_o && rtc_osc_en_o && !cpu_clk_en_o) else $error("idle gated wrong domain");
    a_standby_osc: assert property (sleeping_o && mode_q == sleep_ctrl_pkg::MODE_OSC_KEPT |-> sys_osc_en_o && !rtc_clk_en_o && periph_clk_en_o == '0) else $error("standby oscillator not kept");
    a_always_wake: assert property (state_q == sleep_ctrl_pkg::ST_SLEEP && (usb_s || port_s || twi_s) |=> state_q != sleep_ctrl_pkg::ST_SLEEP) else $error("common wake source ignored");
    a_osc_wait: assert property (state_q == sleep_ctrl_pkg::ST_OSC_WAIT && !osc_rdy_s |=> state_q == sleep_ctrl_pkg::ST_OSC_WAIT && sys_osc_en_o && cpu_halt_o) else $error("halt left before oscillator ready");
    a_nvm_finish: assert property (sleeping_o && $past(nvm_busy_i) |-> nvm_clk_en_o) else $error("nvm clock cut during programming");
    a_periph_stop: assert property (state_d == sleep_ctrl_pkg::ST_ACTIVE && periph_stop_i[0] |=> !periph_clk_en_o[0]) else $error("peripheral clock not stopped");
    a_mode_held: assert property (sleeping_o && $past(sleeping_o) |-> $stable(mode_q)) else $error("mode changed during sleep");
    a_reset_wake: assert property (@(posedge ref_clk_i) disable iff (1'b0) rst_i |=> reset_vector_o && !sleeping_o && cpu_clk_en_o) else $error("reset did not restart");

    c_idle_cycle: cover property (sleeping_o && mode_q == sleep_ctrl_pkg::MODE_IDLE ##[1:50] resume_isr_o);
    c_deep_cycle: cover property (state_q == sleep_ctrl_pkg::ST_OSC_WAIT ##[1:50] resume_isr_o);
    c_refused: cover property (state_q == sleep_ctrl_pkg::ST_ACTIVE && sleep_exec_i && !mode_ok);
    c_reset_in_sleep: cover property (@(posedge ref_clk_i) disable iff (1'b0) sleeping_o && rst_i);
endmodule

// ==== tb/osc_ready_model.sv ====
`timescale 1ns/100ps
module osc_ready_model #(
    parameter int START_CYCLES = 6
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // oscillator enable from controller
    input wire logic sys_osc_en_i,
    // oscillator ready to controller
    output logic sys_osc_ready_o
);
    logic [7:0] count_q;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !sys_osc_en_i) begin
            count_q <= 8'h00;
        end else if (count_q < 8'(START_CYCLES)) begin
            count_q <= count_q + 8'h01;
        end
    end

    // low while stopped, high only after start-up has elapsed
    assign sys_osc_ready_o = (count_q == 8'(START_CYCLES));
endmodule

// ==== tb/sleep_mode_controller_bench.sv ====
`timescale 1ns/100ps
module sleep_mode_controller_bench;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic exec = 1'b0;
    logic allow = 1'b0;
    logic [2:0] msel = 3'h0;
    logic nvm_busy = 1'b0;
    logic [7:0] pstop = 8'h00;
    logic any_irq = 1'b0;
    logic rtc_irq = 1'b0;
    logic rtc_run = 1'b0;
    logic [2:0] async_w = 3'h0;
    logic osc_rdy, cpu_en, nvm_en, rtc_en, osc_en, rtc_osc, halt, sleeping, isr, rvec;
    logic [7:0] per_en;
    logic [2:0] mode;
    int failures = 0;
    int compares = 0;

    always #4 ref_clk_i = ~ref_clk_i;

    sleep_mode_controller sleep_mode_controller_i (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sleep_exec_i(exec),
        .sleep_entry_allow_i(allow), .sleep_mode_select_i(msel), .nvm_busy_i(nvm_busy),
        .periph_stop_i(pstop), .any_irq_i(any_irq), .rtc_irq_i(rtc_irq),
        .rtc_run_i(rtc_run), .usb_resume_i(async_w[0]), .port_async_irq_i(async_w[1]),
        .twi_addr_match_i(async_w[2]), .sys_osc_ready_i(osc_rdy), .cpu_clk_en_o(cpu_en),
        .nvm_clk_en_o(nvm_en), .periph_clk_en_o(per_en), .rtc_clk_en_o(rtc_en),
        .sys_osc_en_o(osc_en), .rtc_osc_en_o(rtc_osc), .cpu_halt_o(halt),
        .sleeping_o(sleeping), .resume_isr_o(isr), .reset_vector_o(rvec), .mode_o(mode));

    osc_ready_model osc_ready_model_i (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sys_osc_en_i(osc_en),
        .sys_osc_ready_o(osc_rdy));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic enter(input logic [2:0] code, input logic al);
        @(negedge ref_clk_i);
        msel = code;
        allow = al;
        exec = 1'b1;
        @(negedge ref_clk_i);
        exec = 1'b0;
    endtask

    task automatic wake_check(output int lat);
        int n;
        lat = 0;
        while (sleeping !== 1'b0 && lat < 60) begin
            @(negedge ref_clk_i);
            lat++;
        end
        chk(8'(sleeping), 8'h00, "no wake");
        any_irq = 1'b0;
        rtc_irq = 1'b0;
        async_w = 3'h0;
        n = 0;
        while (halt === 1'b1 && n < 20) begin
            chk(8'(cpu_en), 8'h01, "cpu clock off in halt");
            @(negedge ref_clk_i);
            n++;
        end
        chk(8'(n), 8'h04, "halt length");
        chk(8'(isr), 8'h01, "no resume");
        @(negedge ref_clk_i);
        chk(8'(isr), 8'h00, "resume not a pulse");
        repeat (6) @(negedge ref_clk_i);
    endtask

    logic [2:0] msel_r[3] = '{sleep_ctrl_pkg::MODE_RSVD_1, sleep_ctrl_pkg::MODE_RSVD_4,
        sleep_ctrl_pkg::MODE_RSVD_5};

    task automatic t_refuse();
        enter(3'h0, 1'b0);
        chk(8'(sleeping), 8'h00, "slept without allow");
        foreach (msel_r[i]) begin
            enter(msel_r[i], 1'b1);
            chk(8'({sleeping, halt}), 8'h00, "reserved code slept");
        end
    endtask

    task automatic t_modes();
        logic [2:0] codes[5] = '{3'h0, 3'h2, 3'h3, 3'h6, 3'h7};
        logic [4:0] e_rtc = 5'b10101;
        logic [4:0] e_osc = 5'h13;
        int lat;
        rtc_run = 1'b1;
        for (int i = 0; i < 5; i++) begin
            enter(codes[i], 1'b1);
            chk(8'(sleeping), 8'h01, "not asleep");
            chk(8'({cpu_en, halt}), 8'h01, "cpu clock in sleep");
            chk(8'(mode), 8'(codes[i]), "mode");
            chk(8'(rtc_en), 8'(e_rtc[4-i]), "rtc clock");
            chk(8'(rtc_osc), 8'(e_rtc[4-i]), "rtc osc");
            chk(8'(osc_en), 8'(e_osc[4-i]), "sys osc");
            chk(per_en, (i == 0) ? 8'hff : 8'h00, "periph clocks");
            if (i != 0) begin
                any_irq = 1'b1;
                rtc_irq = (codes[i] == 3'h2 || codes[i] == 3'h6);
                repeat (8) @(negedge ref_clk_i);
                chk(8'(sleeping), 8'h01, "woke by mode-gated source");
                any_irq = 1'b0;
                rtc_irq = 1'b0;
            end
            async_w[i % 3] = 1'b1;
            wake_check(lat);
            chk(8'(lat > 8), 8'(!e_osc[4-i]), "osc start-up in latency");
        end
    endtask

    task automatic t_rtc_idle();
        int lat;
        enter(3'h3, 1'b1);
        rtc_irq = 1'b1;
        wake_check(lat);
        pstop = 8'h05;
        enter(3'h0, 1'b1);
        chk(per_en, 8'hfa, "periph stop in idle");
        nvm_busy = 1'b1;
        @(negedge ref_clk_i);
        chk(8'(nvm_en), 8'h01, "nvm stopped while busy");
        nvm_busy = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        chk(8'(nvm_en), 8'h00, "nvm clock in idle");
        any_irq = 1'b1;
        wake_check(lat);
        chk(per_en, 8'hfa, "periph stop in active");
        pstop = 8'h00;
    endtask

    task automatic t_reset_sleep();
        enter(3'h2, 1'b1);
        rst_i = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        chk(8'({sleeping, halt, rvec}), 8'h01, "reset in sleep");
        rst_i = 1'b0;
        @(negedge ref_clk_i);
        chk(8'({rvec, cpu_en}), 8'h01, "restart");
    endtask

    task automatic close_out();
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #(20000 * sleep_ctrl_pkg::CLK_PERIOD_NS);
        failures++;
        close_out();
    end

    initial begin
        repeat (4) @(negedge ref_clk_i);
        chk(8'({rvec, cpu_en, halt}), 8'h06, "in reset");
        rst_i = 1'b0;
        @(negedge ref_clk_i);
        chk(8'(rvec), 8'h00, "reset vector after release");
        t_refuse();
        t_modes();
        t_rtc_idle();
        t_reset_sleep();
        close_out();
    end
endmodule
